// ===== rtl/eesw_top.sv
`default_nettype none
module eesw_top #(
	parameter int WR_CYC = eesw_pkg::WR_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_chip_enable_strap,
	input wire logic i_write_protect_input,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	output logic o_busy,
	output logic o_id_locked,
	output logic [eesw_pkg::ADDR_W-1:0] o_addr_counter
);
	// ==================================================================
	// Link domain and crossings
	eesw_link_if lnk ();

	eesw_bit_sampler u_sampler (
		.i_scl(i_scl),
		.i_rstn(i_rstn),
		.i_sda(i_sda),
		.lnk(lnk)
	);

	logic scl_s, sda_s, strap_s, wp_s, tgl_s;

	// Reset to the idle bus levels so no false Start or Stop follows reset
	eesw_sync #(.W(5), .RST_VAL(eesw_pkg::SYNC_RST)) u_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d({i_scl, i_sda, i_chip_enable_strap, i_write_protect_input, lnk.bit_tgl}),
		.o_q({scl_s, sda_s, strap_s, wp_s, tgl_s})
	);

	logic scl_q, sda_q, tgl_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			tgl_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			tgl_q <= tgl_s;
		end
	end

	// ==================================================================
	// State
	eesw_pkg::eesw_state_e state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic ack_r;
	logic sda_oe_n_r;
	logic sda_o_r;
	logic is_id_r;
	logic lock_sel_r;
	logic lock_pend_r;
	logic locked_r;
	logic have_data_r;
	logic [eesw_pkg::PAGE_W-1:0] page_r;
	logic [7:0] lo_r;
	logic [7:0] last_lo_r;
	logic [eesw_pkg::ADDR_W-1:0] addr_r;
	logic [eesw_pkg::WR_CNT_W-1:0] wr_cnt_r;
	logic [7:0] buf_r [0:eesw_pkg::PAGE_BYTES-1];
	logic [eesw_pkg::PAGE_BYTES-1:0] buf_vld_r;
	logic [7:0] mem [0:eesw_pkg::MEM_BYTES-1];
	logic [eesw_pkg::ECC_W-1:0] ecc_mem [0:eesw_pkg::GROUPS-1];
	logic [7:0] id_mem [0:eesw_pkg::PAGE_BYTES-1];

	// ==================================================================
	// Bus events
	logic busy, active, start_ev, stop_ev, bit_ev, fall_ev, byte_done;
	logic trig_write, wr_last, sel_match, sel_write, data_ok, store_en, buf_clr;
	logic [7:0] rx_byte;

	always_comb begin
		busy = (state_r == eesw_pkg::ST_WRITE);
		active = !busy && (state_r != eesw_pkg::ST_IDLE);
		start_ev = !busy && scl_s && sda_q && !sda_s;
		stop_ev = !busy && scl_s && !sda_q && sda_s;
		bit_ev = tgl_s ^ tgl_q;
		fall_ev = scl_q && !scl_s;
		rx_byte = {shift_r[6:0], lnk.bit_val};
		byte_done = active && bit_ev && (cnt_r == eesw_pkg::CNT_LAST_DATA);
		trig_write = (state_r == eesw_pkg::ST_DATA) && (cnt_r == eesw_pkg::CNT_STOP_SLOT) && have_data_r;
		wr_last = busy && (wr_cnt_r == eesw_pkg::WR_CNT_W'(WR_CYC - 1));
		sel_match = ((rx_byte[7:eesw_pkg::SEL_TYPE_LSB] == eesw_pkg::TYPE_MEM)
			|| (rx_byte[7:eesw_pkg::SEL_TYPE_LSB] == eesw_pkg::TYPE_ID))
			&& (rx_byte[eesw_pkg::SEL_CE_BIT] == strap_s);
		sel_write = !rx_byte[eesw_pkg::SEL_RW_BIT];
		data_ok = !wp_s && !(is_id_r && locked_r);
		store_en = byte_done && (state_r == eesw_pkg::ST_DATA) && data_ok && !lock_sel_r;
		buf_clr = byte_done && (state_r == eesw_pkg::ST_DEVSEL) && sel_match && sel_write;
	end

	// ==================================================================
	// Protocol sequencing
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= eesw_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ack_r <= 1'b0;
			is_id_r <= 1'b0;
			lock_sel_r <= 1'b0;
			lock_pend_r <= 1'b0;
			have_data_r <= 1'b0;
			page_r <= '0;
			lo_r <= 8'h00;
			last_lo_r <= 8'h00;
			addr_r <= '0;
			wr_cnt_r <= '0;
		end else if (start_ev) begin
			state_r <= eesw_pkg::ST_DEVSEL;
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
		end else if (stop_ev) begin
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			wr_cnt_r <= '0;
			state_r <= trig_write ? eesw_pkg::ST_WRITE : eesw_pkg::ST_IDLE;
		end else if (busy) begin
			wr_cnt_r <= wr_cnt_r + 1'b1;
			if (wr_last) begin
				state_r <= eesw_pkg::ST_IDLE;
				have_data_r <= 1'b0;
				lock_pend_r <= 1'b0;
				addr_r <= {page_r, 8'(last_lo_r + 8'h01)};
			end
		end else if (active && bit_ev) begin
			if (cnt_r < eesw_pkg::CNT_ACK_DRIVE) begin
				shift_r <= rx_byte;
				cnt_r <= cnt_r + 4'h1;
			end else begin
				cnt_r <= eesw_pkg::CNT_ACK_DONE;
			end
			if (cnt_r == eesw_pkg::CNT_LAST_DATA) begin
				unique case (state_r)
					eesw_pkg::ST_DEVSEL: begin
						ack_r <= sel_match;
						is_id_r <= (rx_byte[7:eesw_pkg::SEL_TYPE_LSB] == eesw_pkg::TYPE_ID);
						page_r[9:8] <= {rx_byte[eesw_pkg::SEL_A17_BIT], rx_byte[eesw_pkg::SEL_A16_BIT]};
						if (!sel_match) begin
							state_r <= eesw_pkg::ST_IGNORE;
						end else if (sel_write) begin
							state_r <= eesw_pkg::ST_ADDR_HI;
							have_data_r <= 1'b0;
							lock_pend_r <= 1'b0;
						end else begin
							state_r <= eesw_pkg::ST_IGNORE;
						end
					end
					eesw_pkg::ST_ADDR_HI: begin
						ack_r <= 1'b1;
						page_r[7:0] <= rx_byte;
						lock_sel_r <= is_id_r && rx_byte[eesw_pkg::HI_LOCK_SEL_BIT];
						state_r <= eesw_pkg::ST_ADDR_LO;
					end
					eesw_pkg::ST_ADDR_LO: begin
						ack_r <= 1'b1;
						lo_r <= rx_byte;
						addr_r <= {page_r, rx_byte};
						state_r <= eesw_pkg::ST_DATA;
					end
					eesw_pkg::ST_DATA: begin
						ack_r <= data_ok;
						if (data_ok) begin
							have_data_r <= 1'b1;
							if (lock_sel_r) begin
								lock_pend_r <= rx_byte[eesw_pkg::LOCK_DATA_BIT];
							end else begin
								last_lo_r <= lo_r;
								lo_r <= lo_r + 8'h01;
							end
						end
					end
					default: begin
						ack_r <= 1'b0;
					end
				endcase
			end
		end else if (active && fall_ev && (cnt_r == eesw_pkg::CNT_ACK_DONE)) begin
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
		end
	end

	// ==================================================================
	// SDA drive, open drain
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sda_oe_n_r <= eesw_pkg::SDA_OE_N_RST;
			sda_o_r <= eesw_pkg::SDA_O_RST;
		end else begin
			sda_o_r <= eesw_pkg::SDA_O_RST;
			if (busy || start_ev || stop_ev) begin
				sda_oe_n_r <= 1'b1;
			end else if (fall_ev && (cnt_r == eesw_pkg::CNT_ACK_DRIVE)) begin
				sda_oe_n_r <= !ack_r;
			end else if (fall_ev && (cnt_r == eesw_pkg::CNT_ACK_DONE)) begin
				sda_oe_n_r <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Page latches
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			buf_vld_r <= '0;
		end else if (buf_clr) begin
			buf_vld_r <= '0;
		end else if (store_en) begin
			buf_vld_r[lo_r] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (store_en) begin
			buf_r[lo_r] <= rx_byte;
		end
	end

	// ==================================================================
	// Array commit with group check bits; ID page commits without them
	function automatic logic [eesw_pkg::ECC_W-1:0] eesw_chk(input logic [31:0] d);
		logic [eesw_pkg::ECC_W-1:0] c;
		c = '0;
		for (int i = 0; i < 32; i++) begin
			if (d[i]) begin
				c = c ^ {1'b1, 6'(i + 1)};
			end
		end
		return c;
	endfunction : eesw_chk

	logic [7:0] wr_idx;
	logic commit_en;
	logic [eesw_pkg::ADDR_W-1:0] grp_base;
	logic [31:0] grp_new;

	always_comb begin
		wr_idx = wr_cnt_r[7:0];
		commit_en = busy && (wr_cnt_r < eesw_pkg::WR_CNT_W'(eesw_pkg::COMMIT_CYC)) && buf_vld_r[wr_idx];
		grp_base = {page_r, wr_idx[7:2], 2'b00};
		grp_new = {mem[grp_base + 18'h3], mem[grp_base + 18'h2], mem[grp_base + 18'h1], mem[grp_base]};
		grp_new[wr_idx[1:0]*8 +: 8] = buf_r[wr_idx];
	end

	always_ff @(posedge i_clk) begin
		if (commit_en && is_id_r) begin
			id_mem[wr_idx] <= buf_r[wr_idx];
		end else if (commit_en) begin
			mem[{page_r, wr_idx}] <= buf_r[wr_idx];
			ecc_mem[grp_base[eesw_pkg::ADDR_W-1:2]] <= eesw_chk(grp_new);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			locked_r <= 1'b0;
		end else if (busy && lock_pend_r) begin
			locked_r <= 1'b1;
		end
	end

	// ==================================================================
	// Outputs
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_busy <= 1'b0;
			o_id_locked <= 1'b0;
			o_addr_counter <= '0;
		end else begin
			o_busy <= busy;
			o_id_locked <= locked_r;
			o_addr_counter <= addr_r;
		end
	end

	assign o_sda_oe_n = sda_oe_n_r;
	assign o_sda_o = sda_o_r;

	// ==================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_busy_sda_off: assert property (busy |=> sda_oe_n_r)
		else $error("SDA driven during write cycle");
	a_start_devsel: assert property (start_ev |=> state_r == eesw_pkg::ST_DEVSEL && cnt_r == 4'h0)
		else $error("Start did not open select phase");
	a_stop_no_write: assert property (stop_ev && !trig_write |=> state_r == eesw_pkg::ST_IDLE)
		else $error("Stop in wrong slot started write");
	a_stop_write: assert property (stop_ev && trig_write |=> busy ##1 busy)
		else $error("Stop in tenth slot did not start write");
	a_wp_nack: assert property (byte_done && state_r == eesw_pkg::ST_DATA && wp_s |=> !ack_r)
		else $error("Protected data byte acknowledged");
	a_sel_mismatch: assert property (byte_done && state_r == eesw_pkg::ST_DEVSEL
		&& rx_byte[eesw_pkg::SEL_CE_BIT] != strap_s |=> state_r == eesw_pkg::ST_IGNORE && !ack_r)
		else $error("Mismatched select answered");
	a_addr_acked: assert property (byte_done && (state_r == eesw_pkg::ST_ADDR_HI
		|| state_r == eesw_pkg::ST_ADDR_LO) |=> ack_r)
		else $error("Address byte not acknowledged");
	a_ack_drive: assert property (!busy && !start_ev && !stop_ev && fall_ev && cnt_r == 4'h8 && ack_r
		|=> !sda_oe_n_r ##1 !sda_oe_n_r)
		else $error("Acknowledge not driven");
	a_page_wrap: assert property (store_en && !start_ev && !stop_ev |=> lo_r == 8'($past(lo_r) + 8'h01))
		else $error("In-page counter did not advance");
	a_locked_nack: assert property (byte_done && state_r == eesw_pkg::ST_DATA && is_id_r && locked_r
		|=> !ack_r)
		else $error("Locked ID page data acknowledged");
	a_busy_ignores: assert property (busy && !wr_last |=> busy)
		else $error("Write cycle interrupted");

	c_write_cycle: cover property (stop_ev && trig_write);
	c_lock_done: cover property ($rose(locked_r));
	c_wp_refused: cover property (byte_done && state_r == eesw_pkg::ST_DATA && wp_s);
	c_poll_mismatch: cover property (byte_done && state_r == eesw_pkg::ST_DEVSEL && !sel_match);
endmodule : eesw_top
`default_nettype wire

// ===== rtl/eesw_pkg.sv
`default_nettype none
package eesw_pkg;
	// ==================================================================
	// Select code layout
	localparam logic [3:0] TYPE_MEM = 4'ha;
	localparam logic [3:0] TYPE_ID = 4'hb;
	localparam int SEL_TYPE_LSB = 4;
	localparam int SEL_CE_BIT = 3;
	localparam int SEL_A17_BIT = 2;
	localparam int SEL_A16_BIT = 1;
	localparam int SEL_RW_BIT = 0;
	localparam int HI_LOCK_SEL_BIT = 2;
	localparam int LOCK_DATA_BIT = 1;
	// ==================================================================
	// Sizes
	localparam int ADDR_W = 18;
	localparam int PAGE_W = 10;
	localparam int PAGE_BYTES = 256;
	localparam int MEM_BYTES = 262144;
	localparam int GROUPS = 65536;
	localparam int ECC_W = 7;
	// ==================================================================
	// Bit slot counts
	localparam logic [3:0] CNT_LAST_DATA = 4'h7;
	localparam logic [3:0] CNT_ACK_DRIVE = 4'h8;
	localparam logic [3:0] CNT_ACK_DONE = 4'h9;
	localparam logic [3:0] CNT_STOP_SLOT = 4'h1;
	// ==================================================================
	// Reset values
	localparam logic SDA_OE_N_RST = 1'b1;
	localparam logic SDA_O_RST = 1'b0;
	// Synchroniser order: scl, sda, strap, protect, toggle; scl and sda idle high, the rest low
	localparam logic [4:0] SYNC_RST = 5'h18;
	// ==================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int INTERNAL_WRITE_TIME_MS = 5;
	localparam int WR_CYC = INTERNAL_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WR_CNT_W = 24;
	localparam int COMMIT_CYC = 256;
	// ==================================================================
	// Protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVSEL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_DATA,
		ST_IGNORE,
		ST_WRITE
	} eesw_state_e;
endpackage : eesw_pkg
`default_nettype wire

// ===== rtl/eesw_link_if.sv
`default_nettype none
interface eesw_link_if;
	logic bit_tgl;
	logic bit_val;
	modport sampler (output bit_tgl, output bit_val);
	modport core (input bit_tgl, input bit_val);
endinterface : eesw_link_if
`default_nettype wire

// ===== rtl/eesw_sync.sv
`default_nettype none
module eesw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_r <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule : eesw_sync
`default_nettype wire

// ===== rtl/eesw_bit_sampler.sv
`default_nettype none
module eesw_bit_sampler (
	input wire logic i_scl,
	input wire logic i_rstn,
	input wire logic i_sda,
	eesw_link_if.sampler lnk
);
	// ==================================================================
	// One toggle per rising clock edge, data held until the next edge
	always_ff @(posedge i_scl or negedge i_rstn) begin
		if (!i_rstn) begin
			lnk.bit_tgl <= 1'b0;
			lnk.bit_val <= 1'b0;
		end else begin
			lnk.bit_tgl <= ~lnk.bit_tgl;
			lnk.bit_val <= i_sda;
		end
	end
endmodule : eesw_bit_sampler
`default_nettype wire

// ===== dv/eesw_master_model.sv
`default_nettype none
module eesw_master_model #(
	parameter int TQ = 32
) (
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// Bus idles high; the link clock stands still between frames
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// ==================================================================
	// Framing
	task automatic start();
		o_sda = 1'b1;
		#(2*TQ) o_scl = 1'b1;
		#(2*TQ) o_sda = 1'b0;
		#(2*TQ) o_scl = 1'b0;
	endtask : start
	task automatic stop();
		o_sda = 1'b0;
		#(2*TQ) o_scl = 1'b1;
		#(2*TQ) o_sda = 1'b1;
		#(2*TQ);
	endtask : stop
	// ==================================================================
	// One byte out, acknowledge sampled in the ninth clock
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda = b[i];
			#(2*TQ) o_scl = 1'b1;
			#(4*TQ) o_scl = 1'b0;
		end
		o_sda = 1'b1;
		#(2*TQ) o_scl = 1'b1;
		#(2*TQ) ack = (i_sda === 1'b0);
		#(2*TQ) o_scl = 1'b0;
	endtask : send_byte
endmodule : eesw_master_model
`default_nettype wire

// ===== dv/i2c_eeprom_slave_write_path_test.sv
`default_nettype none
module i2c_eeprom_slave_write_path_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WR_CYC = 2000;
	localparam int LIMIT = 100000;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic strap = 1'b0;
	logic wp = 1'b0;
	logic sda_o;
	logic sda_oe_n;
	logic busy;
	logic locked;
	logic [eesw_pkg::ADDR_W-1:0] ctr;
	wire m_scl;
	wire m_sda;
	// Open drain with pull-up: the device pulls low only with enable low and data low
	wire sda_w = m_sda & (sda_oe_n | sda_o);
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	// ==================================================================
	// Instances
	eesw_top #(.WR_CYC(WR_CYC)) DUT (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_scl(m_scl),
		.i_sda(sda_w),
		.i_chip_enable_strap(strap),
		.i_write_protect_input(wp),
		.o_sda_o(sda_o),
		.o_sda_oe_n(sda_oe_n),
		.o_busy(busy),
		.o_id_locked(locked),
		.o_addr_counter(ctr)
	);
	eesw_master_model #(.TQ(32)) m (
		.o_scl(m_scl),
		.o_sda(m_sda),
		.i_sda(sda_w)
	);
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end
	// ==================================================================
	// Helpers
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [7:0] sel(input logic [3:0] t, input logic [1:0] h, input logic rw, input logic ce);
		return {t, ce, h, rw};
	endfunction : sel
	function automatic logic [17:0] exp_ctr(input logic [1:0] h, input logic [15:0] a, input int n);
		return {h, a[15:8], 8'(a[7:0] + n)};
	endfunction : exp_ctr
	task automatic wr(input logic [7:0] s, input logic [15:0] a, input int n, input logic ea, input logic [7:0] orm);
		logic ak;
		m.start();
		m.send_byte(s, ak);
		chk("select ack", 1, ak);
		m.send_byte(a[15:8], ak);
		chk("addr hi ack", 1, ak);
		m.send_byte(a[7:0], ak);
		chk("addr lo ack", 1, ak);
		for (int i = 0; i < n; i++) begin
			m.send_byte(8'($urandom()) | orm, ak);
			chk("data ack", ea, ak);
		end
		m.stop();
	endtask : wr
	task automatic wait_cycle(input logic e);
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 40) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		chk("busy", e, busy);
		k = 0;
		while (busy === 1'b1 && k < WR_CYC + 40) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		chk("busy end", 0, busy);
	endtask : wait_cycle
	// ==================================================================
	// Main sequence
	initial begin
		logic [15:0] a;
		logic [1:0] h;
		logic ak;
		void'($urandom(32'h616f126f));
		strap = 1'($urandom());
		repeat (4) @(posedge i_clk);
		#1 i_rstn = 1'b1;
		repeat (4) @(posedge i_clk);
		chk("oe_n reset", 1, sda_oe_n);
		chk("busy reset", 0, busy);
		chk("locked reset", 0, locked);
		chk("ctr reset", 0, ctr);
		$display("test reset done");
		a = 16'($urandom());
		h = 2'($urandom());
		wr(sel(eesw_pkg::TYPE_MEM, h, 0, strap), a, 1, 1, 8'h00);
		wait_cycle(1);
		chk("ctr byte", exp_ctr(h, a, 1), ctr);
		$display("test byte write done");
		a = {8'($urandom()), 8'hfe};
		wr(sel(eesw_pkg::TYPE_MEM, h, 0, strap), a, 3, 1, 8'h00);
		m.start();
		m.send_byte(sel(eesw_pkg::TYPE_MEM, h, 0, strap), ak);
		chk("poll while busy", 0, ak);
		for (int i = 0; i < 12 && !ak; i++) begin
			m.start();
			m.send_byte(sel(eesw_pkg::TYPE_MEM, h, 0, strap), ak);
		end
		chk("poll ack", 1, ak);
		m.start();
		m.send_byte(sel(eesw_pkg::TYPE_MEM, h, 1, strap), ak);
		chk("read after poll", 1, ak);
		m.stop();
		chk("ctr wrap", exp_ctr(h, a, 3), ctr);
		$display("test page wrap and polling done");
		@(posedge i_clk);
		#1 wp = 1'b1;
		wr(sel(eesw_pkg::TYPE_MEM, h, 0, strap), a, 2, 0, 8'h00);
		wait_cycle(0);
		@(posedge i_clk);
		#1 wp = 1'b0;
		$display("test write protect done");
		a = 16'($urandom());
		wr(sel(eesw_pkg::TYPE_MEM, h, 0, strap), a, 0, 1, 8'h00);
		chk("ctr loaded", {h, a}, ctr);
		wait_cycle(0);
		$display("test early stop done");
		m.start();
		m.send_byte(sel(eesw_pkg::TYPE_MEM, h, 0, !strap), ak);
		chk("strap mismatch", 0, ak);
		m.stop();
		m.start();
		m.send_byte(sel(4'h5, h, 0, strap), ak);
		chk("type mismatch", 0, ak);
		m.start();
		m.send_byte(sel(eesw_pkg::TYPE_MEM, h, 1, strap), ak);
		chk("read select", 1, ak);
		m.stop();
		$display("test select decode done");
		wr(sel(eesw_pkg::TYPE_ID, 2'($urandom()), 0, strap), 16'h0012, 2, 1, 8'h00);
		wait_cycle(1);
		wr(sel(eesw_pkg::TYPE_ID, 0, 0, strap), 16'h0400, 1, 1, 8'h02);
		wait_cycle(1);
		chk("locked", 1, locked);
		wr(sel(eesw_pkg::TYPE_ID, 0, 0, strap), 16'h0012, 1, 0, 8'h00);
		wait_cycle(0);
		$display("test id page done");
		print_verdict();
	end
endmodule : i2c_eeprom_slave_write_path_test
`default_nettype wire
